// [design/rim_pkg.sv]
/*
  Package for the reference input monitor: register indices, reset values,
  field layouts, carrier structs and the millisecond timing count.
  Assumes a 200 MHz system clock and APB with one register per 32-bit word.
*/
package rim_pkg;

  // printed offsets are register indices; byte address is index * 4
  localparam logic [11:0] RIM_IDX_PER0   = 12'h404;
  localparam logic [11:0] RIM_IDX_PER7   = 12'h40b;
  localparam logic [11:0] RIM_IDX_LIM0   = 12'h40c;
  localparam logic [11:0] RIM_IDX_LIM1   = 12'h40d;
  localparam logic [11:0] RIM_IDX_LIM2   = 12'h40e;
  localparam logic [11:0] RIM_IDX_HYS    = 12'h40f;
  localparam logic [11:0] RIM_IDX_VT0    = 12'h410;
  localparam logic [11:0] RIM_IDX_VT1    = 12'h411;
  localparam logic [11:0] RIM_IDX_VT2    = 12'h412;
  localparam logic [11:0] RIM_IDX_JT0    = 12'h413;
  localparam logic [11:0] RIM_IDX_JT1    = 12'h414;
  localparam logic [11:0] RIM_IDX_STATE  = 12'h418;
  localparam logic [11:0] RIM_IDX_EVENT  = 12'h419;
  localparam logic [11:0] RIM_IDX_MASK   = 12'h41a;

  localparam logic [59:0] RIM_RST_PERIOD = 60'h000000000000000;
  localparam logic [23:0] RIM_RST_LIMIT  = 24'h0186a0;
  localparam logic [2:0]  RIM_RST_HYS    = 3'h3;
  localparam logic [19:0] RIM_RST_VTIME  = 20'h0000a;
  localparam logic [15:0] RIM_RST_JTOL   = 16'h0000;
  localparam logic [2:0]  RIM_RST_MASK   = 3'h0;

  // event and state bit positions
  localparam int RIM_BIT_FAULT  = 0;
  localparam int RIM_BIT_VALID  = 1;
  localparam int RIM_BIT_JITTER = 2;

  // one millisecond in cycles of the 5 ns clock
  localparam int RIM_MS_NS       = 1000000;
  localparam int RIM_CLK_PS      = 5000;
  localparam int RIM_MS_CYCLES   = RIM_MS_NS / RIM_CLK_PS * 1000;

  typedef struct packed {
    logic [59:0] period;
    logic [23:0] limit;
    logic [2:0]  hys;
    logic [19:0] vtime;
    logic [15:0] jtol;
  } rim_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] err_ppb;
    logic [15:0] jit_ns;
  } rim_meas_t;

  typedef struct packed {
    logic jitter;
    logic valid;
    logic fault;
  } rim_stat_t;

endpackage

// [design/rim_ref_monitor.sv]
/*
  Reference input monitor qualification: limit registers, fault decision
  with hysteresis, millisecond validation timer, excess-jitter flag, APB
  slave and masked interrupt.
  Assumes a measurement engine on clk that strobes one frequency error
  (ppb, magnitude) and one rms jitter (ns) per measurement, and that reads
  the nominal period from cfg.period.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rim_ref_monitor #(
  parameter int unsigned MS_CYCLES = rim_pkg::RIM_MS_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rim_pkg::rim_meas_t meas,
  output rim_pkg::rim_cfg_t      cfg,
  output rim_pkg::rim_stat_t     mon_status,
  output logic                   irq
);
  import rim_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES);

  // hysteresis amount as a fraction of the limit
  function automatic logic [23:0] hys_amount(input logic [23:0] lim,
                                             input logic [2:0]  code);
    logic [23:0] amt;
    amt = 24'h0;
    unique case (code)
      3'h0: amt = 24'h0;
      3'h1: amt = lim >> 5;
      3'h2: amt = lim >> 4;
      3'h3: amt = lim >> 3;
      3'h4: amt = lim >> 2;
      3'h5: amt = lim >> 1;
      3'h6: amt = (lim >> 1) + (lim >> 2);
      3'h7: amt = lim - (lim >> 3);
    endcase
    return amt;
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    logic [11:0] i;
    i = a[13:2];
    return (a[15:14] == 2'h0) && (a[1:0] == 2'h0) &&
           (((i >= RIM_IDX_PER0) && (i <= RIM_IDX_JT1)) ||
            ((i >= RIM_IDX_STATE) && (i <= RIM_IDX_MASK)));
  endfunction

  rim_cfg_t    cfg_q, cfg_d;
  logic [2:0]  mask_q, mask_d;
  logic [2:0]  event_q, event_d;
  logic        irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [MSW-1:0] ms_cnt_q, ms_cnt_d;
  logic [19:0] vcnt_q, vcnt_d;
  logic        fault_q, fault_d;
  logic        valid_q, valid_d;
  logic        jit_q, jit_d;

  logic [11:0] idx;
  logic [7:0]  wb;
  logic        wr_en;
  logic        setup;
  logic        tick;
  logic [2:0]  ev;
  logic [23:0] clr_level;

  assign idx   = paddr[13:2];
  assign wb    = pwdata[7:0];
  assign setup = psel & ~penable;
  // unmapped writes are dropped and answered with pslverr
  assign wr_en = psel & penable & pwrite & ~err_q;

  // zero wait states: read data was captured in the setup cycle
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & err_q;
  assign prdata     = rdata_q;
  assign cfg        = cfg_q;
  assign mon_status = '{jitter: jit_q, valid: valid_q, fault: fault_q};
  assign irq        = irq_q;

  // configuration registers
  always_comb begin
    logic [63:0] per;
    logic [2:0]  bsel;
    per    = {4'h0, cfg_q.period};
    bsel   = 3'(idx - RIM_IDX_PER0);
    cfg_d  = cfg_q;
    if (wr_en) begin
      case (idx) inside
        [RIM_IDX_PER0:RIM_IDX_PER7]: begin
          per[8*bsel +: 8] = wb;
          cfg_d.period = per[59:0];
        end
        RIM_IDX_LIM0: cfg_d.limit[7:0]   = wb;
        RIM_IDX_LIM1: cfg_d.limit[15:8]  = wb;
        RIM_IDX_LIM2: cfg_d.limit[23:16] = wb;
        RIM_IDX_HYS:  cfg_d.hys          = wb[2:0];
        // software keeps these away from 0x00000 and 0xfffff
        RIM_IDX_VT0:  cfg_d.vtime[7:0]   = wb;
        RIM_IDX_VT1:  cfg_d.vtime[15:8]  = wb;
        RIM_IDX_VT2:  cfg_d.vtime[19:16] = wb[3:0];
        RIM_IDX_JT0:  cfg_d.jtol[7:0]    = wb;
        RIM_IDX_JT1:  cfg_d.jtol[15:8]   = wb;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q  <= '{period: RIM_RST_PERIOD, limit: RIM_RST_LIMIT,
                  hys: RIM_RST_HYS, vtime: RIM_RST_VTIME,
                  jtol: RIM_RST_JTOL};
    end else begin
      cfg_q  <= cfg_d;
    end
  end

  // interrupt mask
  always_comb begin
    mask_d = mask_q;
    if (wr_en && (idx == RIM_IDX_MASK)) begin
      mask_d = wb[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= RIM_RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  // monitor decisions
  assign clr_level = cfg_q.limit - hys_amount(cfg_q.limit, cfg_q.hys);
  assign tick      = (ms_cnt_q == MSW'(MS_CYCLES - 1));

  // the prescaler runs free, so the first counted millisecond after a
  // fault clears may be short by up to MS_CYCLES - 1 cycles
  always_comb begin
    ms_cnt_d = tick ? '0 : ms_cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // fault and jitter levels move only on a measurement strobe, except that jitter is forced low while jtol is 0
  always_comb begin
    fault_d = fault_q;
    jit_d   = jit_q;
    if (meas.valid) begin
      if (meas.err_ppb > cfg_q.limit) begin
        fault_d = 1'b1;
      // clear only below limit minus hysteresis
      end else if (meas.err_ppb < clr_level) begin
        fault_d = 1'b0;
      end
      jit_d = meas.jit_ns > cfg_q.jtol;
    end
    if (cfg_q.jtol == 16'h0) begin
      jit_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
      jit_q   <= 1'b0;
    end else begin
      fault_q <= fault_d;
      jit_q   <= jit_d;
    end
  end

  // validation timer; a fault at the strobe wins over a tick in that cycle
  always_comb begin
    vcnt_d  = vcnt_q;
    valid_d = valid_q;
    if (fault_d) begin
      vcnt_d  = 20'h0;
      valid_d = 1'b0;
    end else if (!valid_q && tick) begin
      vcnt_d = vcnt_q + 20'h1;
      if (vcnt_d >= cfg_q.vtime) begin
        valid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vcnt_q  <= 20'h0;
      valid_q <= 1'b0;
    end else begin
      vcnt_q  <= vcnt_d;
      valid_q <= valid_d;
    end
  end

  // events, read path and interrupt
  always_comb begin
    ev = 3'h0;
    ev[RIM_BIT_FAULT]  = fault_d & ~fault_q;
    ev[RIM_BIT_VALID]  = valid_d & ~valid_q;
    ev[RIM_BIT_JITTER] = jit_d & ~jit_q;
    event_d = event_q;
    if (wr_en && (idx == RIM_IDX_EVENT)) begin
      event_d = event_q & ~wb[2:0];
    end
    // a new event beats a simultaneous clear
    event_d = event_d | ev;
    irq_d   = |(event_d & mask_d);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_q <= 3'h0;
      irq_q   <= 1'b0;
    end else begin
      event_q <= event_d;
      irq_q   <= irq_d;
    end
  end

  // read data is captured in the setup cycle so the access needs no wait
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d   = ~mapped(paddr);
      rdata_d = 32'h0;
      case (idx) inside
        [RIM_IDX_PER0:RIM_IDX_PER7]:
          rdata_d[7:0] = 8'({4'h0, cfg_q.period} >>
                            (8 * 3'(idx - RIM_IDX_PER0)));
        RIM_IDX_LIM0:  rdata_d[7:0] = cfg_q.limit[7:0];
        RIM_IDX_LIM1:  rdata_d[7:0] = cfg_q.limit[15:8];
        RIM_IDX_LIM2:  rdata_d[7:0] = cfg_q.limit[23:16];
        RIM_IDX_HYS:   rdata_d[2:0] = cfg_q.hys;
        RIM_IDX_VT0:   rdata_d[7:0] = cfg_q.vtime[7:0];
        RIM_IDX_VT1:   rdata_d[7:0] = cfg_q.vtime[15:8];
        RIM_IDX_VT2:   rdata_d[3:0] = cfg_q.vtime[19:16];
        RIM_IDX_JT0:   rdata_d[7:0] = cfg_q.jtol[7:0];
        RIM_IDX_JT1:   rdata_d[7:0] = cfg_q.jtol[15:8];
        RIM_IDX_STATE: rdata_d[2:0] = {jit_q, valid_q, fault_q};
        RIM_IDX_EVENT: rdata_d[2:0] = event_q;
        RIM_IDX_MASK:  rdata_d[2:0] = mask_q;
        default: ;
      endcase
      if (err_d) begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

endmodule
`default_nettype wire

// [bench/rim_ref_monitor_checker.sv]
/*
  Checker for the reference input monitor: fault, hysteresis, validation,
  jitter and period register relations at the top module's ports.
  Assumes one clock, asynchronous active-low reset, bound to every instance.
*/
`timescale 1ns/100ps
`default_nettype none
module rim_ref_monitor_checker #(
  parameter int unsigned MS_CYCLES = rim_pkg::RIM_MS_CYCLES
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [15:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire rim_pkg::rim_meas_t meas,
  input wire rim_pkg::rim_cfg_t  cfg,
  input wire rim_pkg::rim_stat_t mon_status
);
  import rim_pkg::*;
  logic [31:0] run_q;
  logic [31:0] run_d;
  logic [23:0] band;

  function automatic logic [23:0] amt(logic [23:0] l, logic [2:0] c);
    case (c)
      3'h0: return 24'h0;
      3'h1: return l >> 5;
      3'h2: return l >> 4;
      3'h3: return l >> 3;
      3'h4: return l >> 2;
      3'h5: return l >> 1;
      3'h6: return (l >> 1) + (l >> 2);
      default: return l - (l >> 3);
    endcase
  endfunction

  // cycles spent out of fault, the floor for a valid declaration
  always_comb begin
    band = cfg.limit - amt(cfg.limit, cfg.hys);
    run_d = mon_status.fault ? 32'h0 : run_q + 32'h1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) run_q <= 32'h0;
    else run_q <= run_d;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_over;
    meas.valid && meas.err_ppb > cfg.limit;
  endsequence
  sequence s_band;
    meas.valid && meas.err_ppb >= band && meas.err_ppb <= cfg.limit;
  endsequence

  a_fault_set: assert property (s_over |=> mon_status.fault)
    else $error("fault missing above limit");
  a_fault_hold: assert property (
    mon_status.fault ##0 s_band |=> mon_status.fault)
    else $error("fault left inside band");
  a_fault_clear: assert property (
    meas.valid && meas.err_ppb < band |=> !mon_status.fault)
    else $error("fault kept below band");
  a_valid_excl: assert property (
    mon_status.fault |-> !mon_status.valid)
    else $error("valid while faulted");
  a_valid_time: assert property (
    $rose(mon_status.valid) |->
    64'(run_q) + MS_CYCLES >= 64'(cfg.vtime) * MS_CYCLES)
    else $error("valid too early");
  a_jit_set: assert property (
    meas.valid && cfg.jtol != 16'h0 && meas.jit_ns > cfg.jtol
    |=> mon_status.jitter)
    else $error("jitter flag missing");
  a_jit_off: assert property (
    cfg.jtol == 16'h0 |=> !mon_status.jitter)
    else $error("jitter flag while disabled");
  a_period_wr: assert property (
    psel && penable && pwrite && paddr == {2'b0, RIM_IDX_PER0, 2'b0}
    |=> cfg.period[7:0] == $past(pwdata[7:0]))
    else $error("period byte not written");
endmodule
bind rim_ref_monitor rim_ref_monitor_checker #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk(clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .meas(meas),
  .cfg(cfg),
  .mon_status(mon_status)
);
`default_nettype wire

// [bench/rim_ref_src.sv]
/*
  Model of the monitored reference: hands one measurement strobe per call.
  Assumes the caller is the bench on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rim_ref_src (
  input  wire logic              clk,
  output var rim_pkg::rim_meas_t meas
);
  import rim_pkg::*;
  initial meas = '0;
  task automatic send(input logic [23:0] e, input logic [15:0] j);
    @(posedge clk);
    meas <= '{1'b1, e, j};
    @(posedge clk);
    // data is meaningless off the strobe, so never leave it looking valid
    meas <= '{1'b0, ~e, ~j};
  endtask
endmodule
`default_nettype wire

// [bench/rim_ref_monitor_tb.sv]
/*
  Bench for the reference input monitor: APB reads are checked from a queue.
  Assumes the design answers with zero wait states and MS_CYCLES of 4.
*/
`timescale 1ns/100ps
`default_nettype none
module rim_ref_monitor_tb;
  import rim_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, e;
  logic        pready, pslverr, irq;
  rim_meas_t   meas;
  rim_cfg_t    cfg;
  rim_stat_t   mon_status;
  int          err_count = 0, checked = 0, seed = 49779, k;
  logic [31:0] exp_q[$];
  logic        exp_s[$];
  logic [11:0] ri[13] = '{12'h404, 12'h40c, 12'h40d, 12'h40e, 12'h40f,
    12'h413, 12'h414, 12'h410, 12'h411, 12'h412, 12'h418, 12'h41a, 12'h415};
  logic [7:0]  rv[13] = '{0, 8'ha0, 8'h86, 8'h1, 8'h3, 0, 0, 8'ha, 0, 0,
    0, 0, 0};
  logic [7:0]  wm[7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h7, 8'hff, 8'hff};
  int          hk[8] = '{0, 8, 16, 32, 64, 128, 192, 224};

  always #2.5 clk = ~clk;
  rim_ref_monitor #(.MS_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .cfg(cfg), .mon_status(mon_status), .irq(irq));
  rim_ref_src src (.clk(clk), .meas(meas));

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    // indices outside the register map must answer with an error
    exp_s.push_back(!((i >= RIM_IDX_PER0 && i <= RIM_IDX_JT1) ||
                      (i >= RIM_IDX_STATE && i <= RIM_IDX_MASK)));
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b0, i, 2'b0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] x);
    exp_q.push_back(x);
    apb(0, i, 0);
  endtask
  task automatic st(input logic [23:0] r, input logic [15:0] j, input int x);
    src.send(r, j);
    rd(12'h418, x);
  endtask
  task automatic ck_irq(input logic x);
    repeat (2) @(posedge clk);
    #1 cmp(irq, x);
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp(prdata, exp_q.pop_front());
    if (psel && penable && pready && exp_s.size() > 0)
      cmp(pslverr, exp_s.pop_front());
  end
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    for (k = 0; k < 13; k++) rd(ri[k], rv[k]);
    for (k = 0; k < 7; k++) begin
      e = $random(seed);
      apb(1, ri[k], e);
      rd(ri[k], e & wm[k]);
    end
    apb(1, 12'h40c, 8'he8);
    apb(1, 12'h40d, 8'h3);
    apb(1, 12'h40e, 0);
    apb(1, 12'h415, 8'h55);
    rd(12'h40c, 8'he8);
    // never pass through an all-zero validation time
    apb(1, 12'h411, 1);
    apb(1, 12'h410, 0);
    for (k = 0; k < 8; k++) begin
      apb(1, 12'h40f, k);
      st(1001, 0, 1);
      st(1000 - 1000 * hk[k] / 256, 0, 1);
      st(999 - 1000 * hk[k] / 256, 0, 0);
    end
    apb(1, 12'h410, 2);
    apb(1, 12'h411, 0);
    st(5000, 0, 1);
    st(0, 0, 0);
    repeat (16) @(posedge clk);
    rd(12'h418, 2);
    st(5000, 0, 1);
    apb(1, 12'h413, 0);
    apb(1, 12'h414, 0);
    st(5000, 16'hffff, 1);
    apb(1, 12'h413, 100);
    st(5000, 101, 5);
    st(5000, 100, 1);
    rd(12'h419, 7);
    ck_irq(0);
    apb(1, 12'h41a, 1);
    ck_irq(1);
    apb(1, 12'h419, 7);
    ck_irq(0);
    rd(12'h419, 0);
    st(0, 0, 0);
    st(5000, 0, 1);
    ck_irq(1);
    @(posedge clk);
    finish_test;
  end
endmodule
`default_nettype wire
